// ### core/cwr_ctl.sv
// Purpose: Controller end: AXI4-Lite orders into host serial frames
// Assumes: AXI on CLK_IN; read line arrives from outside the domain
// Notes:   One frame at a time; orders while busy are refused
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "cwr_regs.svh"
module cwr_ctl #(
   parameter int HALF_CYC = `CWR_STROBE_HALF_CYC
) (
   input  wire logic        CLK_IN,
   input  wire logic        RESETN_IN,
   input  wire logic        CLK_EN_IN,
   input  wire logic [4:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [4:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   output logic             IRQ_OUT,
   cwr_if.host              BUS
);
   cwr_pkg::cwr_ctl_st_t q;
   cwr_pkg::cwr_ctl_st_t d;
   logic                 wr_go;
   logic                 rd_go;

   localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 1);

   // Both write channels are taken together in one edge
   assign wr_go         = S_AXI_AWVALID & S_AXI_WVALID & ~q.bvalid;
   assign rd_go         = S_AXI_ARVALID & ~q.rvalid;
   assign S_AXI_AWREADY = wr_go;
   assign S_AXI_WREADY  = wr_go;
   assign S_AXI_ARREADY = rd_go;

   always_comb begin
      logic [2:0]  ev;
      logic [31:0] wd;
      logic        idle;
      ev   = 3'h0;
      wd   = S_AXI_WDATA;
      idle = (q.ph == cwr_pkg::CWR_IDLE);
      d    = q;
      d.rl_s = {q.rl_s[0], BUS.dev_read_line};

      // Strobe sequencer
      case (q.ph)
         cwr_pkg::CWR_IDLE: begin
            d.ce  = 1'b0;
            d.stb = 1'b0;
         end
         cwr_pkg::CWR_ALO, cwr_pkg::CWR_DLO: begin
            d.dout = q.rd && q.ph == cwr_pkg::CWR_DLO ? 1'b0 : q.sr[0];
            if (q.tmr == 8'h00) begin
               d.tmr = HALF_M1;
               d.stb = 1'b1;
               if (q.ph == cwr_pkg::CWR_DLO && q.rd) begin
                  d.rx[q.bitn[5:0]] = q.rl_s[1];
               end
               d.ph = q.ph == cwr_pkg::CWR_ALO ? cwr_pkg::CWR_AHI : cwr_pkg::CWR_DHI;
            end else begin
               d.tmr = q.tmr - 8'h01;
            end
         end
         cwr_pkg::CWR_AHI, cwr_pkg::CWR_DHI: begin
            if (q.tmr == 8'h00) begin
               d.tmr  = HALF_M1;
               d.stb  = 1'b0;
               d.sr   = {1'b0, q.sr[63:1]};
               d.bitn = q.bitn + 7'h01;
               if (d.bitn != q.lim) begin
                  d.ph = q.ph == cwr_pkg::CWR_AHI ? cwr_pkg::CWR_ALO : cwr_pkg::CWR_DLO;
               end else if (q.ph == cwr_pkg::CWR_AHI) begin
                  d.ph = cwr_pkg::CWR_CEUP;
               end else begin
                  d.ce = 1'b0;
                  d.ph = cwr_pkg::CWR_CEDN;
               end
            end else begin
               d.tmr = q.tmr - 8'h01;
            end
         end
         cwr_pkg::CWR_CEUP: begin
            d.ce   = 1'b1;
            d.bitn = 7'h00;
            d.lim  = q.rd ? {1'b0, q.bitn[5:0]} : 7'(8 * (int'(q.len) + 2));
            d.ph   = cwr_pkg::CWR_DLO;
         end
         cwr_pkg::CWR_CEDN: begin
            if (q.tmr == 8'h00) begin
               d.ph = cwr_pkg::CWR_IDLE;
               if (q.rd) begin
                  d.rdat = q.rx;
                  ev[`CWR_IRQ_RD_DONE] = 1'b1;
               end else begin
                  ev[`CWR_IRQ_WR_DONE] = 1'b1;
               end
            end else begin
               d.tmr = q.tmr - 8'h01;
            end
         end
         default: d.ph = cwr_pkg::CWR_IDLE;
      endcase

      // Register writes
      if (wr_go) begin
         d.bvalid = 1'b1;
         d.bresp  = 2'b00;
         case (S_AXI_AWADDR)
            `CWR_REG_CTRL: begin
               if (S_AXI_WSTRB[0]) begin
                  d.rsel = wd[`CWR_CTRL_RSEL_LSB +: 2];
                  d.mon  = wd[`CWR_CTRL_MON];
               end
               if (S_AXI_WSTRB[1]) begin
                  d.len  = wd[`CWR_CTRL_LEN_LSB +: 3];
                  d.chip = wd[`CWR_CTRL_CHIP_LSB +: 2];
               end
               if (wd[`CWR_CTRL_GO_WR] | wd[`CWR_CTRL_GO_RD]) begin
                  if (!idle
                      || (wd[`CWR_CTRL_GO_WR] && d.len > `CWR_LEN_MAX)
                      || (!wd[`CWR_CTRL_GO_WR] && d.rsel == 2'h0 && !d.mon)) begin
                     ev[`CWR_IRQ_REFUSED] = 1'b1;
                  end else begin
                     d.ph   = cwr_pkg::CWR_ALO;
                     d.tmr  = HALF_M1;
                     d.bitn = 7'h00;
                     d.lim  = `CWR_HDR_BITS;
                     d.rx   = 48'h0000_0000_0000;
                     d.rd   = ~wd[`CWR_CTRL_GO_WR];
                     if (wd[`CWR_CTRL_GO_WR]) begin
                        // Address, header with reserved zeros, then status bits
                        d.sr = {q.cs, 1'b0, d.len, 2'b00, d.chip,
                                `CWR_ADDR_CS_WRITE};
                     end else begin
                        d.sr = {56'h00_0000_0000_0000, `CWR_ADDR_FLAGS + {6'h00, d.rsel}};
                     end
                  end
               end
            end
            `CWR_REG_IRQ_STAT: d.irq = q.irq & ~wd[2:0];
            `CWR_REG_IRQ_MASK: d.mask = wd[2:0];
            `CWR_REG_CS_LO:    d.cs[31:0] = wd;
            `CWR_REG_CS_HI:    d.cs[47:32] = wd[15:0];
            default:           d.bresp = 2'b10;
         endcase
      end else if (q.bvalid && S_AXI_BREADY) begin
         d.bvalid = 1'b0;
      end

      // Read bit count of a read frame is kept in bitn until chip enable rises
      if (q.rd && q.ph == cwr_pkg::CWR_AHI && d.ph == cwr_pkg::CWR_CEUP) begin
         case (q.rsel)
            2'h2:    d.bitn = {1'b0, `CWR_RD_BITS_RX_CS};
            2'h3:    d.bitn = {1'b0, `CWR_RD_BITS_BURST};
            default: d.bitn = {1'b0, `CWR_RD_BITS_FLAGS};
         endcase
      end

      // Sticky events; a new event beats the clear
      d.irq = d.irq | ev;

      // Register reads
      if (rd_go) begin
         d.rvalid = 1'b1;
         d.rresp  = 2'b00;
         case (S_AXI_ARADDR)
            `CWR_REG_CTRL:     d.rdata = {18'h0_0000, q.chip, 1'b0, q.len, 3'h0,
                                          q.mon, q.rsel, 2'h0};
            `CWR_REG_STATE:    d.rdata = {31'h0000_0000, ~idle};
            `CWR_REG_IRQ_STAT: d.rdata = {29'h0000_0000, q.irq};
            `CWR_REG_IRQ_MASK: d.rdata = {29'h0000_0000, q.mask};
            `CWR_REG_CS_LO:    d.rdata = q.cs[31:0];
            `CWR_REG_CS_HI:    d.rdata = {16'h0000, q.cs[47:32]};
            `CWR_REG_RD_LO:    d.rdata = q.rdat[31:0];
            `CWR_REG_RD_HI:    d.rdata = {16'h0000, q.rdat[47:32]};
            default: begin
               d.rdata = 32'h0000_0000;
               d.rresp = 2'b10;
            end
         endcase
      end else if (q.rvalid && S_AXI_RREADY) begin
         d.rvalid = 1'b0;
      end
   end

   // State register, frozen while the clock enable is low
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         q <= '0;
      end else if (CLK_EN_IN) begin
         q <= d;
      end
   end

   assign S_AXI_BVALID        = q.bvalid;
   assign S_AXI_BRESP         = q.bresp;
   assign S_AXI_RVALID        = q.rvalid;
   assign S_AXI_RRESP         = q.rresp;
   assign S_AXI_RDATA         = q.rdata;
   assign IRQ_OUT             = |(q.irq & q.mask);
   assign BUS.chip_enable     = q.ce;
   assign BUS.shift_strobe    = q.stb;
   assign BUS.host_write_line = q.dout;
endmodule : cwr_ctl

// ### core/cwr_regs.svh
// Purpose: Shared constants of the host serial bus blocks
// Assumes: 20 MHz system clock on both ends
// Notes:   Definitions only
`ifndef CWR_REGS_SVH
`define CWR_REGS_SVH
// Host serial bus addresses
`define CWR_ADDR_CS_WRITE  8'hE9
`define CWR_ADDR_FLAGS     8'hEA
`define CWR_ADDR_GPIO_FS   8'hEB
`define CWR_ADDR_RX_CS     8'hEC
`define CWR_ADDR_BURST     8'hED
// Highest legal length code
`define CWR_LEN_MAX        3'h5
// Frame bit counts
`define CWR_HDR_BITS       7'h08
`define CWR_RD_BITS_FLAGS  6'h18
`define CWR_RD_BITS_RX_CS  6'h30
`define CWR_RD_BITS_BURST  6'h10
// Strobe timing
`define CWR_CLK_NS         50
`define CWR_STROBE_HALF_NS 400
`define CWR_STROBE_HALF_CYC \
   ((`CWR_STROBE_HALF_NS + `CWR_CLK_NS - 1) / `CWR_CLK_NS)
// Controller register byte offsets
`define CWR_REG_CTRL       5'h00
`define CWR_REG_STATE      5'h04
`define CWR_REG_IRQ_STAT   5'h08
`define CWR_REG_IRQ_MASK   5'h0C
`define CWR_REG_CS_LO      5'h10
`define CWR_REG_CS_HI      5'h14
`define CWR_REG_RD_LO      5'h18
`define CWR_REG_RD_HI      5'h1C
// Control fields
`define CWR_CTRL_GO_WR     0
`define CWR_CTRL_GO_RD     1
`define CWR_CTRL_RSEL_LSB  2
`define CWR_CTRL_MON       4
`define CWR_CTRL_LEN_LSB   8
`define CWR_CTRL_CHIP_LSB  12
// Interrupt bits
`define CWR_IRQ_WR_DONE    0
`define CWR_IRQ_RD_DONE    1
`define CWR_IRQ_REFUSED    2
`define CWR_IRQ_RST        3'h0
`endif

// ### core/cwr_pkg.sv
// Purpose: Types of the host serial bus blocks
// Assumes: Nothing
// Notes:   State of each end is one packed struct
package cwr_pkg;
   typedef enum logic [2:0] {
      CWR_IDLE, CWR_ALO, CWR_AHI, CWR_CEUP, CWR_DLO, CWR_DHI, CWR_CEDN
   } cwr_phase_t;

   typedef struct packed {
      logic [2:0]  ce_s;
      logic [2:0]  stb_s;
      logic [1:0]  din_s;
      logic [6:0]  pin_s1;
      logic [6:0]  pin_s2;
      logic [6:0]  pin_p;
      logic [3:0]  gp_s1;
      logic [3:0]  gp_s2;
      logic [7:0]  addr_sr;
      logic [7:0]  addr;
      logic [6:0]  cnt;
      logic [55:0] wr_sr;
      logic [47:0] pend;
      logic [2:0]  pend_len;
      logic        pend_v;
      logic [47:0] tx_cs;
      logic        tx_load;
      logic [47:0] rd_sr;
      logic        chg;
   } cwr_dev_st_t;

   typedef struct packed {
      cwr_phase_t  ph;
      logic [7:0]  tmr;
      logic [6:0]  bitn;
      logic [6:0]  lim;
      logic        rd;
      logic [63:0] sr;
      logic [47:0] rx;
      logic        ce;
      logic        stb;
      logic        dout;
      logic [1:0]  rl_s;
      logic [1:0]  rsel;
      logic        mon;
      logic [2:0]  len;
      logic [1:0]  chip;
      logic [47:0] cs;
      logic [47:0] rdat;
      logic [2:0]  irq;
      logic [2:0]  mask;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
   } cwr_ctl_st_t;
endpackage : cwr_pkg

// ### core/cwr_if.sv
// Purpose: Four-wire host serial bus between controller and device
// Assumes: Both ends on the same system clock
// Notes:   Device samples all lines through synchronisers
`timescale 1ns/1ps
interface cwr_if;
   logic chip_enable;
   logic shift_strobe;
   logic host_write_line;
   logic dev_read_line;

   modport dev  (input  chip_enable, shift_strobe, host_write_line,
                 output dev_read_line);
   modport host (output chip_enable, shift_strobe, host_write_line,
                 input  dev_read_line);
endinterface : cwr_if

// ### core/cwr_dev.sv
// Purpose: Device end of the host serial bus: status write and reads
// Assumes: Bus lines, data pins and GP input levels asynchronous, others on CLK_IN
// Notes:   Address byte shifts with chip enable low, data with it high
// Operation
// - Address 0xE9 frames write channel status
// - Header bits zero and one carry chip address
// - Header bits two, three, seven sent zero
// - Length code picks 8 to 48 bits
// - Controller gives eight plus length strobes
// - Wrong strobe count may drop the data
// - New status applies at next block start
// - Frame bit eight is status bit zero
// - Address 0xEB bits 16-23 are test only
// - 0xEA returns presence, flags, stream flags
// - 0xEB bits 0-3 give input levels
// - 0xEB gives fs result and counter
// - 0xEC returns first 48 received status bits
// - 0xED returns burst preamble Pc bits
// - Monitor must be on before presence read
// - Input change flag clears after its read
`timescale 1ns/1ps
`include "cwr_regs.svh"
module cwr_dev #(
   parameter logic [1:0] CHIP_ADDR = 2'h0
) (
   input  wire logic        CLK_IN,
   input  wire logic        RESETN_IN,
   input  wire logic        CLK_EN_IN,
   cwr_if.dev               BUS,
   input  wire logic        BLOCK_START_IN,
   input  wire logic [7:0]  INPUT_PRESENCE_IN,
   input  wire logic        INPUT_MONITOR_ON_IN,
   input  wire logic [7:0]  STATUS_FLAGS_IN,
   input  wire logic [7:0]  STREAM_FLAGS_IN,
   input  wire logic [6:0]  DATA_PIN_IN,
   input  wire logic [3:0]  GP_INPUT_LEVEL_IN,
   input  wire logic [3:0]  FS_CALC_RESULT_IN,
   input  wire logic [7:0]  FS_COUNTER_VALUE_IN,
   input  wire logic [47:0] RX_CS_IN,
   input  wire logic [15:0] BURST_PC_IN,
   output logic      [47:0] TX_CS_OUT,
   output logic             TX_CS_LOAD_OUT,
   output logic             INPUT_CHANGE_FLAG_OUT
);
   cwr_pkg::cwr_dev_st_t q;
   cwr_pkg::cwr_dev_st_t d;

   // Next-state logic of the whole device end
   always_comb begin
      logic        ce;
      logic        ce_up;
      logic        ce_dn;
      logic        stb_up;
      logic        bitv;
      logic [2:0]  hlen;
      logic [6:0]  need;
      logic [47:0] snap;
      ce     = 1'b0;
      ce_up  = 1'b0;
      ce_dn  = 1'b0;
      stb_up = 1'b0;
      bitv   = 1'b0;
      hlen   = 3'h0;
      need   = 7'h00;
      snap   = 48'h0000_0000_0000;
      d      = q;

      // Synchronisers; the first stage feeds only the second
      d.ce_s   = {q.ce_s[1:0], BUS.chip_enable};
      d.stb_s  = {q.stb_s[1:0], BUS.shift_strobe};
      d.din_s  = {q.din_s[0], BUS.host_write_line};
      d.pin_s1 = DATA_PIN_IN;
      d.pin_s2 = q.pin_s1;
      d.pin_p  = q.pin_s2;
      d.gp_s1  = GP_INPUT_LEVEL_IN;
      d.gp_s2  = q.gp_s1;
      d.tx_load = 1'b0;

      ce     = q.ce_s[1];
      ce_up  = q.ce_s[1] & ~q.ce_s[2];
      ce_dn  = ~q.ce_s[1] & q.ce_s[2];
      stb_up = q.stb_s[1] & ~q.stb_s[2];
      bitv   = q.din_s[1];
      hlen   = q.wr_sr[6:4];
      need   = 7'(8 * (int'(hlen) + 2));

      // Read snapshot chosen by the address shift register
      case (q.addr_sr)
         `CWR_ADDR_FLAGS: begin
            snap[7:0]   = INPUT_PRESENCE_IN & {8{INPUT_MONITOR_ON_IN}};
            snap[15:8]  = STATUS_FLAGS_IN;
            snap[9]     = q.chg;
            snap[23:16] = STREAM_FLAGS_IN;
         end
         `CWR_ADDR_GPIO_FS: begin
            snap[3:0]   = q.gp_s2;
            snap[7:4]   = FS_CALC_RESULT_IN;
            snap[15:8]  = FS_COUNTER_VALUE_IN;
            snap[23:16] = 8'h00;
         end
         `CWR_ADDR_RX_CS: snap = RX_CS_IN;
         `CWR_ADDR_BURST: snap[15:0] = BURST_PC_IN;
         default:         snap = 48'h0000_0000_0000;
      endcase

      // Strobe edges: address while low, frame bits while high
      if (stb_up) begin
         if (!ce) begin
            d.addr_sr = {bitv, q.addr_sr[7:1]};
         end else begin
            if (q.addr == `CWR_ADDR_CS_WRITE && q.cnt < 7'h38) begin
               d.wr_sr[q.cnt[5:0]] = bitv;
            end
            if (q.cnt != 7'h7F) begin
               d.cnt = q.cnt + 7'h01;
            end
            d.rd_sr = {1'b0, q.rd_sr[47:1]};
         end
      end

      // Chip enable rise: latch address and load read data
      if (ce_up) begin
         d.addr  = q.addr_sr;
         d.cnt   = 7'h00;
         d.wr_sr = 56'h00_0000_0000_0000;
         d.rd_sr = snap;
      end

      // Pending status goes out at the block start
      if (BLOCK_START_IN && q.pend_v) begin
         for (int i = 0; i < 48; i++) begin
            if (i < 8 * (int'(q.pend_len) + 1)) begin
               d.tx_cs[i] = q.pend[i];
            end
         end
         d.pend_v  = 1'b0;
         d.tx_load = 1'b1;
      end

      // Chip enable fall: accept a well-formed write
      if (ce_dn) begin
         if (q.addr == `CWR_ADDR_CS_WRITE
             && hlen <= `CWR_LEN_MAX
             && q.wr_sr[1:0] == CHIP_ADDR
             && q.cnt == need) begin
            d.pend     = q.wr_sr[55:8];
            d.pend_len = hlen;
            d.pend_v   = 1'b1;
         end
         if (q.addr == `CWR_ADDR_FLAGS) begin
            d.chg = 1'b0;
         end
      end

      // Any pin change sets the flag; set beats clear
      if (|(q.pin_s2 ^ q.pin_p)) begin
         d.chg = 1'b1;
      end
   end

   // State register, frozen while the clock enable is low
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         q <= '0;
      end else if (CLK_EN_IN) begin
         q <= d;
      end
   end

   // Outputs straight from state
   assign BUS.dev_read_line     = q.rd_sr[0];
   assign TX_CS_OUT             = q.tx_cs;
   assign TX_CS_LOAD_OUT        = q.tx_load;
   assign INPUT_CHANGE_FLAG_OUT = q.chg;
endmodule : cwr_dev

// ### test/cwr_bus_asserts.sv
// Purpose: Checks of the host serial bus lines between both ends
// Assumes: Strobe halves of 8 cycles, one clock domain
// Notes:   Watches the wires only
`timescale 1ns/1ps
module cwr_bus_asserts (
   input  wire logic CLK_IN,
   input  wire logic RESETN_IN,
   input  wire logic chip_enable,
   input  wire logic shift_strobe,
   input  wire logic host_write_line,
   input  wire logic dev_read_line
);
   logic [7:0] addr_q;
   logic [7:0] hdr_q;
   logic [6:0] na_q;
   logic [6:0] nd_q;
   logic [6:0] nd_exp;

   // Strobes a write frame must carry with chip enable high
   assign nd_exp = {1'b0, hdr_q[6:4] + 3'h2, 3'h0};

   // Copies of address byte, header and strobe counts
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         addr_q <= 8'h00;
         hdr_q  <= 8'h00;
         na_q   <= 7'h00;
         nd_q   <= 7'h00;
      end else if ($fell(chip_enable)) begin
         na_q <= 7'h00;
         nd_q <= 7'h00;
      end else if ($rose(shift_strobe) && !chip_enable) begin
         addr_q <= {host_write_line, addr_q[7:1]};
         na_q   <= na_q + 7'h01;
      end else if ($rose(shift_strobe)) begin
         if (nd_q < 7'h08) begin
            hdr_q[nd_q[2:0]] <= host_write_line;
         end
         nd_q <= nd_q + 7'h01;
      end
   end

   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RESETN_IN);

   sequence s_hi_half;
      shift_strobe [*8] ##1 !shift_strobe;
   endsequence
   sequence s_wr_end;
      $fell(chip_enable) && addr_q == 8'hE9;
   endsequence

   chk_strobe_high_len: assert property ($rose(shift_strobe) |-> s_hi_half)
      else $error("strobe high half has wrong length");
   chk_strobe_low_len: assert property ($fell(shift_strobe) |-> !shift_strobe [*8])
      else $error("strobe low half too short");
   chk_data_steady: assert property (shift_strobe |-> $stable(host_write_line))
      else $error("write line moved while strobe high");
   chk_ce_strobe_low: assert property ($changed(chip_enable) |-> !shift_strobe)
      else $error("chip enable moved while strobe high");
   chk_addr_byte_len: assert property ($rose(chip_enable) |-> na_q == 7'h08)
      else $error("address byte not eight strobes");
   chk_addr_known: assert property ($rose(chip_enable) |-> addr_q inside {[8'hE9:8'hED]})
      else $error("frame sent to unknown address");
   chk_frame_bytes: assert property ($fell(chip_enable) |-> nd_q[2:0] == 3'h0 && nd_q >= 7'h10)
      else $error("data phase not whole bytes");
   chk_write_len: assert property (s_wr_end |-> nd_q == nd_exp)
      else $error("write strobe count differs from length code");
   chk_hdr_reserved: assert property (s_wr_end |-> hdr_q[7] == 1'b0 && hdr_q[3:2] == 2'h0)
      else $error("reserved header bit set");
   // Every read frame shifts out fully, so the read line rests low between frames
   chk_read_idle_low: assert property (!chip_enable |-> !dev_read_line)
      else $error("read line not low outside a frame");
endmodule : cwr_bus_asserts

// ### test/tb_top.sv
// Purpose: Self-checking bench with both bus ends joined
// Assumes: Device chip address 2
// Notes:   Registers reached over AXI4-Lite
`timescale 1ns/1ps
`include "cwr_regs.svh"
module tb_top;
   logic        clk_in = 1'b0;
   logic        resetn_in = 1'b0;
   logic [4:0]  aw_a = 5'h00;
   logic [4:0]  ar_a = 5'h00;
   logic [31:0] w_d = 32'h0000_0000;
   logic        aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
   logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, irq, tx_ld, chg;
   logic [1:0]  b_resp, r_resp;
   logic [31:0] r_d, lo, hi;
   logic        bs = 1'b0, saw_ld = 1'b0;
   logic [6:0]  pins = 7'h00;
   logic        clk_en = 1'b1, mon_on = 1'b1;
   logic [3:0]  wstrb = 4'hF, gp_lvl = 4'h6;
   logic [47:0] rx_cs = 48'h1234_5678_9ABC;
   logic [15:0] pc = 16'hBEEF;
   logic [47:0] tx_cs, cs, mask;
   logic [47:0] tx_exp = 48'h0000_0000_0000;
   logic [47:0] ex [4];
   int          err_total = 0;
   int          cmp_count = 0;

   // Clock and reset
   always #25 clk_in = ~clk_in;
   initial begin
      repeat (3) @(posedge clk_in);
      resetn_in <= 1'b1;
   end

   cwr_if bus_if ();
   cwr_ctl cwr_ctl_inst (.CLK_IN(clk_in), .RESETN_IN(resetn_in), .CLK_EN_IN(clk_en),
      .S_AXI_AWADDR(aw_a), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_rdy),
      .S_AXI_WDATA(w_d), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(w_v), .S_AXI_WREADY(w_rdy),
      .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_r),
      .S_AXI_ARADDR(ar_a), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_rdy),
      .S_AXI_RDATA(r_d), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_r),
      .IRQ_OUT(irq), .BUS(bus_if.host));
   cwr_dev #(.CHIP_ADDR(2'h2)) cwr_dev_inst (.CLK_IN(clk_in), .RESETN_IN(resetn_in),
      .CLK_EN_IN(clk_en), .BUS(bus_if.dev), .BLOCK_START_IN(bs),
      .INPUT_PRESENCE_IN(8'h96), .INPUT_MONITOR_ON_IN(mon_on), .STATUS_FLAGS_IN(8'hA5),
      .STREAM_FLAGS_IN(8'h3C), .DATA_PIN_IN(pins), .GP_INPUT_LEVEL_IN(gp_lvl),
      .FS_CALC_RESULT_IN(4'h9), .FS_COUNTER_VALUE_IN(8'h5A), .RX_CS_IN(rx_cs),
      .BURST_PC_IN(pc), .TX_CS_OUT(tx_cs), .TX_CS_LOAD_OUT(tx_ld),
      .INPUT_CHANGE_FLAG_OUT(chg));
   cwr_bus_asserts cwr_bus_asserts_inst (.CLK_IN(clk_in), .RESETN_IN(resetn_in),
      .chip_enable(bus_if.chip_enable), .shift_strobe(bus_if.shift_strobe),
      .host_write_line(bus_if.host_write_line), .dev_read_line(bus_if.dev_read_line));

   // Remember any load pulse of the applied status
   always @(posedge clk_in) if (tx_ld === 1'b1) saw_ld <= 1'b1;

   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_in);
      aw_a <= a; w_d <= d; aw_v <= 1'b1; w_v <= 1'b1; b_r <= 1'b1;
      #1; while (!(aw_rdy && w_rdy)) begin @(posedge clk_in); #1; end
      @(posedge clk_in);
      aw_v <= 1'b0; w_v <= 1'b0;
      #1; while (b_v !== 1'b1) begin @(posedge clk_in); #1; end
      chk("bresp", 48'h0, {46'h0, b_resp});
      @(posedge clk_in);
      b_r <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [4:0] a, output logic [31:0] d);
      @(posedge clk_in);
      ar_a <= a; ar_v <= 1'b1; r_r <= 1'b1;
      #1; while (!ar_rdy) begin @(posedge clk_in); #1; end
      @(posedge clk_in);
      ar_v <= 1'b0;
      #1; while (r_v !== 1'b1) begin @(posedge clk_in); #1; end
      d = r_d;
      @(posedge clk_in);
      r_r <= 1'b0;
   endtask : axi_rd

   // Poll one status bit, then clear it by writing one
   task automatic wait_irq(input int b);
      logic [31:0] v;
      v = 32'h0000_0000;
      while (v[b] !== 1'b1) axi_rd(`CWR_REG_IRQ_STAT, v);
      axi_wr(`CWR_REG_IRQ_STAT, 32'h0000_0001 << b);
   endtask : wait_irq

   function automatic logic [31:0] ctrl(input logic [1:0] ch, input logic [2:0] len,
                                        input logic m, input logic [1:0] rs, go);
      return {18'h0, ch, 1'b0, len, 3'h0, m, rs, go};
   endfunction : ctrl

   task automatic block_start();
      @(posedge clk_in);
      saw_ld <= 1'b0;
      bs <= 1'b1;
      @(posedge clk_in);
      bs <= 1'b0;
      repeat (3) @(posedge clk_in);
   endtask : block_start

   task automatic send_cs(input logic [1:0] ch, input logic [2:0] len);
      axi_wr(`CWR_REG_CS_LO, cs[31:0]);
      axi_wr(`CWR_REG_CS_HI, {16'h0, cs[47:32]});
      axi_wr(`CWR_REG_CTRL, ctrl(ch, len, 1'b0, 2'h0, 2'b01));
   endtask : send_cs

   // Every legal length code, applied only at block start, high bits kept
   task automatic t_write_lengths();
      for (int l = 0; l < 6; l++) begin
         cs = ~tx_exp ^ 48'h5A5A_0F0F_3C3C;
         mask = (48'h1 << (8 * (l + 1))) - 48'h1;
         send_cs(2'h2, l[2:0]);
         wait_irq(`CWR_IRQ_WR_DONE);
         chk("tx_cs_held", tx_exp, tx_cs);
         tx_exp = (tx_exp & ~mask) | (cs & mask);
         block_start();
         chk("tx_cs_applied", tx_exp, tx_cs);
         chk("tx_load_pulse", 48'h1, {47'h0, saw_ld});
      end
   endtask : t_write_lengths

   // Wrong chip, reserved length, busy and monitor-off refusals
   task automatic t_refusals();
      cs = ~tx_exp;
      send_cs(2'h1, 3'h5);
      wait_irq(`CWR_IRQ_WR_DONE);
      block_start();
      chk("tx_cs_other_chip", tx_exp, tx_cs);
      axi_wr(`CWR_REG_CTRL, ctrl(2'h2, 3'h6, 1'b0, 2'h0, 2'b01));
      wait_irq(`CWR_IRQ_REFUSED);
      cs = tx_exp;
      send_cs(2'h2, 3'h0);
      axi_wr(`CWR_REG_CTRL, ctrl(2'h2, 3'h0, 1'b0, 2'h0, 2'b01));
      wait_irq(`CWR_IRQ_REFUSED);
      wait_irq(`CWR_IRQ_WR_DONE);
      axi_wr(`CWR_REG_CTRL, ctrl(2'h0, 3'h0, 1'b0, 2'h0, 2'b10));
      wait_irq(`CWR_IRQ_REFUSED);
   endtask : t_refusals

   // All four read addresses, masked to their frame widths
   task automatic t_reads();
      ex[0] = 48'h0000_003C_A596;
      ex[1] = 48'h0000_0000_5A96;
      ex[2] = 48'h1234_5678_9ABC;
      ex[3] = 48'h0000_0000_BEEF;
      for (int s = 0; s < 4; s++) begin
         axi_wr(`CWR_REG_CTRL, ctrl(2'h0, 3'h0, 1'b1, s[1:0], 2'b10));
         wait_irq(`CWR_IRQ_RD_DONE);
         axi_rd(`CWR_REG_RD_LO, lo);
         axi_rd(`CWR_REG_RD_HI, hi);
         mask = (s == 2) ? 48'hFFFF_FFFF_FFFF : (s == 3) ? 48'hFFFF : 48'hFF_FFFF;
         chk("read_frame", ex[s], {hi[15:0], lo} & mask);
      end
      // Presence bits read zero while the monitor input is off
      mon_on <= 1'b0;
      axi_wr(`CWR_REG_CTRL, ctrl(2'h0, 3'h0, 1'b1, 2'h0, 2'b10));
      wait_irq(`CWR_IRQ_RD_DONE);
      axi_rd(`CWR_REG_RD_LO, lo);
      chk("presence_off", 48'h0000_003C_A500, {24'h00_0000, lo[23:0]});
      mon_on <= 1'b1;
   endtask : t_reads

   // Pin change flag shows in the read and clears after it
   task automatic t_change();
      @(posedge clk_in);
      pins <= 7'h04;
      repeat (10) @(posedge clk_in);
      chk("chg_set", 48'h1, {47'h0, chg});
      axi_wr(`CWR_REG_CTRL, ctrl(2'h0, 3'h0, 1'b1, 2'h0, 2'b10));
      wait_irq(`CWR_IRQ_RD_DONE);
      axi_rd(`CWR_REG_RD_LO, lo);
      chk("chg_read", 48'h1, {47'h0, lo[9]});
      chk("chg_cleared", 48'h0, {47'h0, chg});
   endtask : t_change

   // Sticky status, masking and write-one clearing of the interrupt
   task automatic t_irq();
      axi_wr(`CWR_REG_CTRL, ctrl(2'h0, 3'h0, 1'b0, 2'h0, 2'b10));
      repeat (4) @(posedge clk_in);
      chk("irq_masked", 48'h0, {47'h0, irq});
      axi_wr(`CWR_REG_IRQ_MASK, 32'h0000_0004);
      chk("irq_raised", 48'h1, {47'h0, irq});
      axi_wr(`CWR_REG_IRQ_STAT, 32'h0000_0004);
      chk("irq_cleared", 48'h0, {47'h0, irq});
      axi_rd(`CWR_REG_IRQ_STAT, lo);
      chk("irq_stat", 48'h0, {16'h0, lo});
   endtask : t_irq

   task automatic report_and_stop();
      if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : report_and_stop

   // Main sequence
   initial begin
      @(posedge resetn_in);
      t_write_lengths();
      t_refusals();
      t_reads();
      t_change();
      t_irq();
      report_and_stop();
   end

   // Watchdog well beyond the expected run
   initial begin
      repeat (60000) @(posedge clk_in);
      err_total++;
      report_and_stop();
   end
endmodule : tb_top
